/* File: shared/moi_pkg.sv */
// Constants, encodings and carrier types of the move/increment datapath
package moi_pkg;
   localparam int INSN_W = 14;
   localparam int FADDR_W = 7;
   localparam int DATA_W = 8;
   // Opcode fields: top six bits of the word for file ops
   localparam logic [5:0] OPC_INC_BITS = 6'h0A;
   localparam logic [5:0] OPC_IORF_BITS = 6'h04;
   localparam logic [5:0] OPC_MOVE_BITS = 6'h08;
   localparam logic [5:0] OPC_ZERO_BITS = 6'h00;
   // Load literal matches only the top two bits
   localparam logic [1:0] OPC_LIT_BITS = 2'h3;
   localparam int OPC_LSB = 8;
   localparam int LIT_OPC_LSB = 12;
   localparam int DEST_BIT = 7;
   // Software port map
   localparam logic [7:0] SW_FILE_LAST = 8'h7F;
   localparam logic [7:0] SW_WORK_ADDR = 8'h80;
   localparam logic [7:0] SW_STAT_ADDR = 8'h81;
   localparam int STAT_Z_BIT = 0;
   // Reset values
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic [7:0] FILE_RESET = 8'h00;

   typedef enum {
      MOI_OP_NOP,
      MOI_OP_INC,
      MOI_OP_IOR,
      MOI_OP_MOVE,
      MOI_OP_STORE,
      MOI_OP_LIT,
      MOI_OP_UNKNOWN
   } moi_op_t;

   // Decoded instruction fields
   typedef struct packed {
      logic             dest_file;
      logic [6:0]       faddr;
      logic [7:0]       literal;
   } moi_fields_t;

   // Software access port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } moi_sw_req_t;
endpackage

/* File: rtl/moi_exec.sv */
// Execution datapath for increment, OR and move instructions
`timescale 1ns/10ps
module moi_exec
#(
   parameter int FADDR_W = moi_pkg::FADDR_W,
   parameter int DATA_W  = moi_pkg::DATA_W
)
(
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   input  wire logic                        insn_valid,
   input  wire logic [moi_pkg::INSN_W-1:0]  insn_word,
   input  wire moi_pkg::moi_sw_req_t        sw_req,
   output logic      [7:0]                  sw_rdata_r,
   output logic      [7:0]                  work_r,
   output logic                             zero_r,
   output logic                             done_r,
   output logic                             unknown_r
);
   localparam int DEPTH = 1 << FADDR_W;

   // The encodings fix a 7-bit address and an 8-bit datum; any other
   // width would shift the opcode fields, so elaboration stops here
   generate
      if (FADDR_W != moi_pkg::FADDR_W || DATA_W != moi_pkg::DATA_W)
      begin
         $error("moi_exec: only 7-bit address and 8-bit data supported");
      end
   endgenerate

   logic [7:0]           file_r [DEPTH];
   moi_pkg::moi_op_t     op;
   moi_pkg::moi_fields_t fld;
   logic [7:0]           fval;
   logic [7:0]           result;
   logic                 wr_work;
   logic                 wr_file;
   logic                 wr_zero;
   logic [5:0]           opc6;
   logic                 sw_file_hit;
   logic                 sw_file_wr;
   logic                 sw_work_wr;
   logic                 sw_stat_wr;

   // Opcode and operand fields; the literal overlaps dest and address,
   // which is harmless since only one of them is used per op
   assign opc6 = insn_word[13:moi_pkg::OPC_LSB];
   assign fld = {insn_word[moi_pkg::DEST_BIT], insn_word[6:0],
                 insn_word[7:0]};

   // Software write selects; addresses above the status slot match
   // nothing and are dropped without effect. Kept apart from the
   // instruction path so a clash on one target is resolved per register.
   always_comb
   begin
      sw_file_hit = (sw_req.addr <= moi_pkg::SW_FILE_LAST);
      sw_file_wr = sw_req.wr && sw_file_hit;
      sw_work_wr = sw_req.wr && (sw_req.addr == moi_pkg::SW_WORK_ADDR);
      sw_stat_wr = sw_req.wr && (sw_req.addr == moi_pkg::SW_STAT_ADDR);
   end

   // Decode; literal op looks only at its top two bits, so the four
   // spare bits may hold anything. Words outside the subset decode as
   // unknown and then behave as a no-op.
   always_comb
   begin
      op = moi_pkg::MOI_OP_UNKNOWN;
      if (insn_word[13:moi_pkg::LIT_OPC_LSB] == moi_pkg::OPC_LIT_BITS)
         op = moi_pkg::MOI_OP_LIT;
      else if (opc6 == moi_pkg::OPC_INC_BITS)
         op = moi_pkg::MOI_OP_INC;
      else if (opc6 == moi_pkg::OPC_IORF_BITS)
         op = moi_pkg::MOI_OP_IOR;
      else if (opc6 == moi_pkg::OPC_MOVE_BITS)
         op = moi_pkg::MOI_OP_MOVE;
      else if (opc6 == moi_pkg::OPC_ZERO_BITS)
      begin
         // Dest bit set means move-to-file, clear means no-op; the
         // address bits of a no-op are not looked at
         if (fld.dest_file)
            op = moi_pkg::MOI_OP_STORE;
         else
            op = moi_pkg::MOI_OP_NOP;
      end
   end

   // Operand read is combinational so every op ends in one cycle. A
   // back-to-back word sees the previous result, because that write
   // lands at the edge that closes the previous cycle.
   assign fval = file_r[fld.faddr];

   // Result and write enables. One shared result bus feeds W, the file
   // and the zero test; the enables alone pick where it goes.
   always_comb
   begin
      result = 8'h00;
      wr_work = 1'b0;
      wr_file = 1'b0;
      wr_zero = 1'b0;
      if (insn_valid)
      begin
         case (op)
            moi_pkg::MOI_OP_INC:
            begin
               result = fval + 8'h01;
               wr_work = ~fld.dest_file;
               wr_file = fld.dest_file;
               wr_zero = 1'b1;
            end
            moi_pkg::MOI_OP_IOR:
            begin
               result = work_r | fval;
               wr_work = ~fld.dest_file;
               wr_file = fld.dest_file;
               wr_zero = 1'b1;
            end
            moi_pkg::MOI_OP_MOVE:
            begin
               // Write-back of the same value doubles as a test
               result = fval;
               wr_work = ~fld.dest_file;
               wr_file = fld.dest_file;
               wr_zero = 1'b1;
            end
            moi_pkg::MOI_OP_STORE:
            begin
               result = work_r;
               wr_file = 1'b1;
            end
            moi_pkg::MOI_OP_LIT:
            begin
               result = fld.literal;
               wr_work = 1'b1;
            end
            default:
            begin
               result = 8'h00;
            end
         endcase
      end
   end

   // File registers. A software write and an instruction write in one
   // cycle both land when they aim at different registers; on the same
   // register the instruction's later assignment wins.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            file_r[i] <= moi_pkg::FILE_RESET;
      end
      else
      begin
         if (sw_file_wr)
            file_r[sw_req.addr[6:0]] <= sw_req.wdata;
         if (wr_file)
            file_r[fld.faddr] <= result;
      end
   end

   // Working register; the instruction beats a software poke
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         work_r <= moi_pkg::WORK_RESET;
      else if (wr_work)
         work_r <= result;
      else if (sw_work_wr)
         work_r <= sw_req.wdata;
   end

   // Zero flag; only ops that own it may change it, so stores to file,
   // literal loads and no-ops keep a test result for a later branch.
   // An instruction update beats a software write of the status slot.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         zero_r <= moi_pkg::ZERO_RESET;
      else if (wr_zero)
         zero_r <= (result == 8'h00);
      else if (sw_stat_wr)
         zero_r <= sw_req.wdata[moi_pkg::STAT_Z_BIT];
   end

   // Completion pulse one edge after each accepted word. An unknown
   // word still pulses done, so the cycle count per word stays fixed.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         done_r <= 1'b0;
         unknown_r <= 1'b0;
      end
      else
      begin
         done_r <= insn_valid;
         unknown_r <= insn_valid && (op == moi_pkg::MOI_OP_UNKNOWN);
      end
   end

   // Software read data, valid the cycle after the strobe only. A read
   // beside an instruction write returns the old value, since both are
   // taken at the same edge; software must read again to see the new.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         sw_rdata_r <= 8'h00;
      else if (!sw_req.rd)
         sw_rdata_r <= 8'h00;
      else if (sw_file_hit)
         sw_rdata_r <= file_r[sw_req.addr[6:0]];
      else if (sw_req.addr == moi_pkg::SW_WORK_ADDR)
         sw_rdata_r <= work_r;
      else if (sw_req.addr == moi_pkg::SW_STAT_ADDR)
         sw_rdata_r <= {7'h00, zero_r};
      else
         sw_rdata_r <= 8'h00;   // Unmapped reads return zero
   end
endmodule

/* File: tb/moi_exec_assertions.sv */
// Concurrent checks on the move/increment datapath ports
`timescale 1ns/10ps
module moi_exec_assertions (
   input wire logic                       clock,
   input wire logic                       reset_n,
   input wire logic                       insn_valid,
   input wire logic [moi_pkg::INSN_W-1:0] insn_word,
   input wire moi_pkg::moi_sw_req_t       sw_req,
   input wire logic [7:0]                 work_r,
   input wire logic                       zero_r,
   input wire logic                       done_r,
   input wire logic                       unknown_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // A software write beside an instruction could move W or Z legally
   wire       q  = insn_valid & ~sw_req.wr;
   wire [6:0] op = insn_word[13:7];

   // Every instruction retires in one cycle
   chk_done_pulse: assert property (insn_valid |=> done_r)
      else $error("done pulse missing");
   chk_done_idle: assert property (!insn_valid |=> !done_r)
      else $error("done without instruction");
   chk_lit_load: assert property (q && insn_word[13:12] == 2'h3
      |=> work_r == $past(insn_word[7:0]) && $stable(zero_r))
      else $error("literal load wrong");
   chk_move_hold: assert property (q && op == 7'h01
      |=> $stable(work_r) && $stable(zero_r))
      else $error("move to file touched W or Z");
   chk_nop_hold: assert property (q && op == 7'h00
      |=> $stable(work_r) && $stable(zero_r))
      else $error("no-op changed state");
   chk_move_file_op_zero: assert property (q && op == 7'h10
      |=> zero_r == (work_r == 8'h00))
      else $error("move file zero flag wrong");
   chk_ior_bits: assert property (q && op == 7'h08
      |=> (work_r | $past(work_r)) == work_r && zero_r == (work_r == 8'h00))
      else $error("or result lost bits");
   chk_inc_zero: assert property (q && op == 7'h14
      |=> zero_r == (work_r == 8'h00))
      else $error("increment zero flag wrong");

   // Main scenarios reached
   cover property (q && op == 7'h14 ##1 zero_r);
   cover property (q && insn_word[13:12] == 2'h3);
   cover property (unknown_r);
endmodule

bind moi_exec moi_exec_assertions u_chk (.clock(clock), .reset_n(reset_n),
   .insn_valid(insn_valid), .insn_word(insn_word), .sw_req(sw_req),
   .work_r(work_r), .zero_r(zero_r), .done_r(done_r),
   .unknown_r(unknown_r));

/* File: tb/moi_exec_test.sv */
// Self-checking bench for the move/increment datapath
`timescale 1ns/10ps
module moi_exec_test;
   logic                 clock, reset_n, insn_valid, zero_r, done_r;
   logic                 unknown_r, z, u;
   logic [13:0]          insn_word, x;
   moi_pkg::moi_sw_req_t sw_req;
   logic [7:0]           sw_rdata_r, work_r, w, r;
   logic [7:0]           fm [128];
   logic [31:0]          v;
   int                   seed = 52;
   int                   miscompares, n_tests;
   // Opcode tops: four of the subset, two literal forms, two foreign
   logic [5:0] tops [8] = '{6'h0A, 6'h04, 6'h08, 6'h00,
                            6'h30, 6'h3F, 6'h05, 6'h15};

   moi_exec u_dut (.clock(clock), .reset_n(reset_n), .insn_valid(insn_valid),
      .insn_word(insn_word), .sw_req(sw_req), .sw_rdata_r(sw_rdata_r),
      .work_r(work_r), .zero_r(zero_r), .done_r(done_r),
      .unknown_r(unknown_r));

   // 25 MHz clock
   always #20 clock = ~clock;

   // Reference model of one instruction
   function automatic void step(input logic [13:0] c);
      r = fm[c[6:0]];
      u = 1'b0;
      if (c[13:12] == 2'h3)
         w = c[7:0];
      else if (c[13:7] == 7'h01)
         fm[c[6:0]] = w;
      else if (c[13:7] != 7'h00)
      begin
         case (c[13:8])
            6'h0A: r = r + 8'h01;
            6'h04: r = r | w;
            6'h08: ;
            default: u = 1'b1;
         endcase
         z = u ? z : (r == 8'h00);
         if (!u && c[7])
            fm[c[6:0]] = r;
         else if (!u)
            w = r;
      end
   endfunction

   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Strobes are left up; the next task replaces them
   task automatic ex(input logic [13:0] c);
      insn_valid <= 1'b1;
      insn_word <= c;
      sw_req <= '0;
      @(posedge clock);
      step(c);
      #1;
      chk(work_r, w);
      chk(8'(zero_r), 8'(z));
      chk(8'(done_r), 8'h01);
      chk(8'(unknown_r), 8'(u));
   endtask

   task automatic swr(input logic [7:0] a, d);
      insn_valid <= 1'b0;
      sw_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      #1;
      if (a < 8'h80)
         fm[a[6:0]] = d;
      else if (a == 8'h80)
         w = d;
      else if (a == 8'h81)
         z = d[0];
   endtask

   task automatic srd(input logic [7:0] a, e);
      insn_valid <= 1'b0;
      sw_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      #1 chk(sw_rdata_r, e);
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      clock = 1'b0;
      reset_n = 1'b0;
      insn_valid = 1'b0;
      insn_word = '0;
      sw_req = '0;
      foreach (fm[i]) fm[i] = 8'h00;
      w = 8'h00;
      z = 1'b0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1 srd(8'h81, 8'h00);
      swr(8'h05, 8'hFF);
      ex(14'h0A85);
      srd(8'h05, 8'h00);
      ex(14'h3F5A);
      ex(14'h0085);
      ex(14'h0885);
      srd(8'h05, 8'h5A);
      srd(8'hC3, 8'h00);
      // Software pokes of W and the status slot, then ops that keep them and a literal load that keeps only Z
      swr(8'h80, 8'hA5);
      ex(14'h0085);
      srd(8'h05, 8'hA5);
      swr(8'h81, 8'h01);
      ex(14'h0000);
      ex(14'h30C3);
      // Random back-to-back traffic with software pokes mixed in
      repeat (300)
      begin
         v = $random(seed);
         x = {tops[v[18:16]], v[7:0]};
         ex(x);
         if (v[20])
            srd({1'b0, x[6:0]}, fm[x[6:0]]);
         if (v[21])
            srd(8'h80, w);
         if (v[24:22] == 3'h0)
            swr(v[31:24], v[15:8]);
      end
      report_and_stop;
   end

   // Hang guard, well beyond the expected run
   initial
   begin
      #400000;
      miscompares++;
      report_and_stop;
   end
endmodule
